/* hw/bridge_strap_pin_mux.sv */
// strap capture, secondary-bus arbitration routing and shared-pin function select
//
// Notes on behaviour
// - with the internal arbiter, the secondary request pins feed the arbiter as master requests.
// - with an external arbiter, request pin zero is the grant given to the bridge.
// - with an external arbiter, grant pin zero carries the bridge's own bus request.
// - arbiter strap 0 selects the internal arbiter and 1 the external one.
// - clock-stop strap 0 disables clock-stop support and 1 enables it.
// - shared pin zero is a GP pin steered by direction bit 0, or the clock-stop input in that mode.
// - shared pin one is the power override output when the field holds 001b or 011b, else GP.
// - pin two high at link reset release turns on link compatibility mode.
// - GP pins two, three, six and seven take direction from the bit of the same index.
// - shared pin four is serial clock when data has a pull-up, else GP pin four.
// - shared pin five is serial data when it has a pull-up, else GP pin five.
// - the secondary-bus reset is driven as an output.
// - the power-management-event input is watched for events from secondary devices.
// - the global reset clears all logic of the block asynchronously.
`timescale 1ns/1ps
module bridge_strap_pin_mux #(
	parameter int REQ_COUNT = strap_mux_pkg::SEC_REQ_COUNT
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET_N,
	input wire logic I_LINK_RESET_N,
	input wire logic I_ARBITER_SOURCE_STRAP,
	input wire logic I_CLOCK_STOP_SUPPORT_STRAP,
	input wire logic I_CLOCK_STOP_MODE,
	input wire logic [strap_mux_pkg::GP_PIN_COUNT-1:0] I_PIN_DIRECTION,
	input wire logic [strap_mux_pkg::GP_PIN_COUNT-1:0] I_GP_OUT_DATA,
	input wire logic [strap_mux_pkg::POWER_OVERRIDE_WIDTH-1:0] I_POWER_OVERRIDE_FIELD,
	input wire logic I_POWER_OVERRIDE_LEVEL,
	input wire logic I_SERIAL_CLK_DRIVE_LOW,
	input wire logic I_SERIAL_DATA_DRIVE_LOW,
	input wire logic [strap_mux_pkg::GP_PIN_COUNT-1:0] I_GP_PIN,
	input wire logic [REQ_COUNT-1:0] I_SEC_REQ_N,
	input wire logic [REQ_COUNT-1:0] I_ARB_GNT_N,
	input wire logic I_ARB_BRIDGE_GRANT,
	input wire logic I_BRIDGE_BUS_REQ,
	input wire logic I_SEC_RESET_ASSERT,
	input wire logic I_PME_N,
	output logic [strap_mux_pkg::GP_PIN_COUNT-1:0] O_GP_PIN,
	output logic [strap_mux_pkg::GP_PIN_COUNT-1:0] O_GP_PIN_OE_N,
	output logic [strap_mux_pkg::GP_PIN_COUNT-1:0] O_GP_IN_DATA,
	output logic [REQ_COUNT-1:0] O_ARB_REQ_N,
	output logic [REQ_COUNT-1:0] O_SEC_GNT_N,
	output logic O_BRIDGE_BUS_GRANT,
	output logic O_EXTERNAL_ARBITER,
	output logic O_CLOCK_STOP_SUPPORT,
	output logic O_CLOCK_STOP_ACTIVE,
	output logic O_CLOCK_STOP_REQUEST_N,
	output logic O_POWER_OVERRIDE_ACTIVE,
	output logic O_SERIAL_BUS_MODE,
	output logic O_SERIAL_CLK_IN,
	output logic O_SERIAL_DATA_IN,
	output logic O_LINK_COMPAT_MODE,
	output logic O_SEC_BUS_RESET_N,
	output logic O_PME_ACTIVE,
	output logic O_PME_EVENT,
	output logic O_STRAPS_VALID
);
	localparam int NPIN = strap_mux_pkg::GP_PIN_COUNT;

	generate
		if (REQ_COUNT < 1 || REQ_COUNT > 16) begin : g_bad_req_count
			$error("REQ_COUNT must lie between 1 and 16");
		end
	endgenerate

	typedef struct packed {
		strap_mux_pkg::strap_state_type state;
		logic arb_ext;
		logic clock_stop_en;
		logic serial_en;
		logic compat_en;
		logic clock_stop_act;
		logic power_override_act;
		logic clock_stop_req_n;
		logic [REQ_COUNT-1:0] arb_req_n;
		logic [REQ_COUNT-1:0] sec_gnt_n;
		logic bridge_grant;
		logic sec_rst_n;
		logic pme_n_d;
		logic pme_event;
		logic pme_active;
	} mux_type;

	mux_type mux_r;
	mux_type mux_nxt;

	logic hold;
	logic [NPIN-1:0] alt_sel;
	logic [NPIN-1:0] alt_oe;
	logic [NPIN-1:0] alt_out;
	logic [NPIN-1:0] pin_in;
	logic link_release;
	logic power_code_hit;

	assign hold = (mux_r.state == strap_mux_pkg::ST_LINK_HELD);
	assign link_release = hold && I_LINK_RESET_N;
	assign power_code_hit =
		(I_POWER_OVERRIDE_FIELD == strap_mux_pkg::POWER_OVERRIDE_CODE_A) ||
		(I_POWER_OVERRIDE_FIELD == strap_mux_pkg::POWER_OVERRIDE_CODE_B);

	always_comb begin
		mux_nxt = mux_r;

		// strap capture at the rising edge of the link reset
		unique case (mux_r.state)
			strap_mux_pkg::ST_LINK_HELD: begin
				if (I_LINK_RESET_N) begin
					mux_nxt.state = strap_mux_pkg::ST_RUN;
					mux_nxt.arb_ext = (I_ARBITER_SOURCE_STRAP == strap_mux_pkg::ARB_EXTERNAL);
					mux_nxt.clock_stop_en =
						(I_CLOCK_STOP_SUPPORT_STRAP == strap_mux_pkg::CLOCK_STOP_ON);
					mux_nxt.serial_en =
						(I_GP_PIN[strap_mux_pkg::PIN_SERIAL_DATA] ==
						strap_mux_pkg::PULL_UP_SEEN);
					mux_nxt.compat_en =
						(I_GP_PIN[strap_mux_pkg::PIN_COMPAT] ==
						strap_mux_pkg::COMPAT_STRAP_ON);
				end
			end
			strap_mux_pkg::ST_RUN: begin
				if (!I_LINK_RESET_N) begin
					mux_nxt.state = strap_mux_pkg::ST_LINK_HELD;
				end
			end
		endcase

		// clock-stop mode needs both the strap and software consent
		mux_nxt.clock_stop_act = !hold && !link_release && mux_r.clock_stop_en &&
			I_CLOCK_STOP_MODE;
		mux_nxt.power_override_act = !hold && power_code_hit;
		if (mux_r.clock_stop_act) begin
			mux_nxt.clock_stop_req_n = pin_in[strap_mux_pkg::PIN_CLOCK_STOP];
		end else begin
			mux_nxt.clock_stop_req_n = strap_mux_pkg::RESET_LEVEL_HIGH;
		end

		// arbitration routing
		if (mux_r.arb_ext == strap_mux_pkg::ARB_EXTERNAL) begin
			mux_nxt.arb_req_n = '1;
			mux_nxt.sec_gnt_n = '1;
			mux_nxt.sec_gnt_n[0] = ~I_BRIDGE_BUS_REQ;
			mux_nxt.bridge_grant = ~I_SEC_REQ_N[0];
		end else begin
			mux_nxt.arb_req_n = I_SEC_REQ_N;
			mux_nxt.sec_gnt_n = I_ARB_GNT_N;
			mux_nxt.bridge_grant = I_ARB_BRIDGE_GRANT;
		end

		// secondary reset follows its request and the link reset
		mux_nxt.sec_rst_n = !I_SEC_RESET_ASSERT && I_LINK_RESET_N;

		// power-management event: level plus a pulse on each new assertion
		mux_nxt.pme_n_d = I_PME_N;
		mux_nxt.pme_active = ~I_PME_N;
		mux_nxt.pme_event = mux_r.pme_n_d && !I_PME_N;
	end

	always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			mux_r.state <= strap_mux_pkg::ST_LINK_HELD;
			mux_r.arb_ext <= strap_mux_pkg::ARB_INTERNAL;
			mux_r.clock_stop_en <= strap_mux_pkg::CLOCK_STOP_OFF;
			mux_r.serial_en <= 1'h0;
			mux_r.compat_en <= 1'h0;
			mux_r.clock_stop_act <= 1'h0;
			mux_r.power_override_act <= 1'h0;
			mux_r.clock_stop_req_n <= 1'h1;
			mux_r.arb_req_n <= '1;
			mux_r.sec_gnt_n <= '1;
			mux_r.bridge_grant <= 1'h0;
			mux_r.sec_rst_n <= 1'h0;
			mux_r.pme_n_d <= 1'h1;
			mux_r.pme_event <= 1'h0;
			mux_r.pme_active <= 1'h0;
		end else begin
			mux_r <= mux_nxt;
		end
	end

	// alternate function of each shared pin
	always_comb begin
		alt_sel = '0;
		alt_oe = '0;
		alt_out = '0;
		// pin zero as clock-stop input never drives
		alt_sel[strap_mux_pkg::PIN_CLOCK_STOP] = mux_r.clock_stop_act;
		alt_sel[strap_mux_pkg::PIN_POWER_OVERRIDE] = mux_r.power_override_act;
		alt_oe[strap_mux_pkg::PIN_POWER_OVERRIDE] = 1'h1;
		alt_out[strap_mux_pkg::PIN_POWER_OVERRIDE] = I_POWER_OVERRIDE_LEVEL;
		// serial pins are open drain: only ever pulled low
		alt_sel[strap_mux_pkg::PIN_SERIAL_CLK] = mux_r.serial_en;
		alt_oe[strap_mux_pkg::PIN_SERIAL_CLK] = I_SERIAL_CLK_DRIVE_LOW;
		alt_sel[strap_mux_pkg::PIN_SERIAL_DATA] = mux_r.serial_en;
		alt_oe[strap_mux_pkg::PIN_SERIAL_DATA] = I_SERIAL_DATA_DRIVE_LOW;
	end

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_pin
			gp_pin_cell u_cell (
				.i_clk(I_SYS_CLK),
				.i_reset_n(I_RESET_N),
				.i_hold(hold),
				.i_alt_sel(alt_sel[gi]),
				.i_alt_oe(alt_oe[gi]),
				.i_alt_out(alt_out[gi]),
				.i_dir(I_PIN_DIRECTION[gi]),
				.i_out(I_GP_OUT_DATA[gi]),
				.i_pin(I_GP_PIN[gi]),
				.o_pin(O_GP_PIN[gi]),
				.o_pin_oe_n(O_GP_PIN_OE_N[gi]),
				.o_in(pin_in[gi])
			);
		end
	endgenerate

	assign O_GP_IN_DATA = pin_in;
	assign O_ARB_REQ_N = mux_r.arb_req_n;
	assign O_SEC_GNT_N = mux_r.sec_gnt_n;
	assign O_BRIDGE_BUS_GRANT = mux_r.bridge_grant;
	assign O_EXTERNAL_ARBITER = mux_r.arb_ext;
	assign O_CLOCK_STOP_SUPPORT = mux_r.clock_stop_en;
	assign O_CLOCK_STOP_ACTIVE = mux_r.clock_stop_act;
	assign O_CLOCK_STOP_REQUEST_N = mux_r.clock_stop_req_n;
	assign O_POWER_OVERRIDE_ACTIVE = mux_r.power_override_act;
	assign O_SERIAL_BUS_MODE = mux_r.serial_en;
	assign O_SERIAL_CLK_IN = pin_in[strap_mux_pkg::PIN_SERIAL_CLK];
	assign O_SERIAL_DATA_IN = pin_in[strap_mux_pkg::PIN_SERIAL_DATA];
	assign O_LINK_COMPAT_MODE = mux_r.compat_en;
	assign O_SEC_BUS_RESET_N = mux_r.sec_rst_n;
	assign O_PME_ACTIVE = mux_r.pme_active;
	assign O_PME_EVENT = mux_r.pme_event;
	assign O_STRAPS_VALID = ~hold;
endmodule : bridge_strap_pin_mux

/* hw/strap_mux_pkg.sv */
// constants and types shared by the strap decoder and its pin cells
package strap_mux_pkg;
	localparam int GP_PIN_COUNT = 8;
	localparam int SEC_REQ_COUNT = 6;
	localparam int POWER_OVERRIDE_WIDTH = 3;

	// strap encodings
	localparam logic ARB_INTERNAL = 1'h0;
	localparam logic ARB_EXTERNAL = 1'h1;
	localparam logic CLOCK_STOP_OFF = 1'h0;
	localparam logic CLOCK_STOP_ON = 1'h1;
	localparam logic PULL_UP_SEEN = 1'h1;
	localparam logic COMPAT_STRAP_ON = 1'h1;

	// power override field codes that claim shared pin one
	localparam logic [POWER_OVERRIDE_WIDTH-1:0] POWER_OVERRIDE_CODE_A = 3'h1;
	localparam logic [POWER_OVERRIDE_WIDTH-1:0] POWER_OVERRIDE_CODE_B = 3'h3;

	// shared pin positions
	localparam int PIN_CLOCK_STOP = 0;
	localparam int PIN_POWER_OVERRIDE = 1;
	localparam int PIN_COMPAT = 2;
	localparam int PIN_SERIAL_CLK = 4;
	localparam int PIN_SERIAL_DATA = 5;

	// pin direction bit value that turns a general-purpose pin into an output
	localparam logic DIR_OUTPUT = 1'h1;

	// reset values
	localparam logic RESET_LEVEL_HIGH = 1'h1;
	localparam logic RESET_LEVEL_LOW = 1'h0;

	typedef enum logic [1:0] {
		ST_LINK_HELD = 2'h1,
		ST_RUN = 2'h2
	} strap_state_type;
endpackage : strap_mux_pkg

/* hw/gp_pin_cell.sv */
// one shared pin: general-purpose or alternate function, registered drive
`timescale 1ns/1ps
module gp_pin_cell (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic i_hold,
	input wire logic i_alt_sel,
	input wire logic i_alt_oe,
	input wire logic i_alt_out,
	input wire logic i_dir,
	input wire logic i_out,
	input wire logic i_pin,
	output logic o_pin,
	output logic o_pin_oe_n,
	output logic o_in
);
	typedef struct packed {
		logic pin;
		logic oe_n;
		logic in;
	} cell_type;

	cell_type cell_r;
	cell_type cell_nxt;

	always_comb begin
		cell_nxt = cell_r;
		cell_nxt.in = i_pin;
		if (i_hold) begin
			// released so the board straps can be read
			cell_nxt.oe_n = strap_mux_pkg::RESET_LEVEL_HIGH;
			cell_nxt.pin = strap_mux_pkg::RESET_LEVEL_LOW;
		end else if (i_alt_sel) begin
			cell_nxt.oe_n = ~i_alt_oe;
			cell_nxt.pin = i_alt_out;
		end else begin
			cell_nxt.oe_n = ~(i_dir == strap_mux_pkg::DIR_OUTPUT);
			cell_nxt.pin = i_out;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			cell_r <= '{pin: 1'h0, oe_n: 1'h1, in: 1'h0};
		end else begin
			cell_r <= cell_nxt;
		end
	end

	assign o_pin = cell_r.pin;
	assign o_pin_oe_n = cell_r.oe_n;
	assign o_in = cell_r.in;
endmodule : gp_pin_cell

/* sim/board_model.sv */
// board straps and pulls resolving the shared pin wires
`timescale 1ns/1ps
module board_model (
	input wire logic [7:0] i_drive,
	input wire logic [7:0] i_oe_n,
	input wire logic [7:0] i_pull_up,
	output logic [7:0] o_pin
);
	// released pins settle to the board pull level
	assign o_pin = (i_drive & ~i_oe_n) | (i_pull_up & i_oe_n);
endmodule : board_model

/* sim/strap_mux_monitor.sv */
// port assertions for the strap decoder and pin mux
`timescale 1ns/1ps
module strap_mux_monitor #(
	parameter int REQ_COUNT = 6
) (
	input wire logic I_SYS_CLK,
	input wire logic I_RESET_N,
	input wire logic I_ARBITER_SOURCE_STRAP,
	input wire logic I_CLOCK_STOP_SUPPORT_STRAP,
	input wire logic [7:0] I_PIN_DIRECTION,
	input wire logic [2:0] I_POWER_OVERRIDE_FIELD,
	input wire logic [7:0] I_GP_PIN,
	input wire logic [REQ_COUNT-1:0] I_SEC_REQ_N,
	input wire logic I_BRIDGE_BUS_REQ,
	input wire logic [7:0] O_GP_PIN_OE_N,
	input wire logic [REQ_COUNT-1:0] O_ARB_REQ_N,
	input wire logic [REQ_COUNT-1:0] O_SEC_GNT_N,
	input wire logic O_BRIDGE_BUS_GRANT,
	input wire logic O_EXTERNAL_ARBITER,
	input wire logic O_CLOCK_STOP_SUPPORT,
	input wire logic O_CLOCK_STOP_ACTIVE,
	input wire logic O_POWER_OVERRIDE_ACTIVE,
	input wire logic O_SERIAL_BUS_MODE,
	input wire logic O_LINK_COMPAT_MODE,
	input wire logic O_STRAPS_VALID
);
	default clocking @(posedge I_SYS_CLK); endclocking
	default disable iff (!I_RESET_N);
	a_int_req_route: assert property ($past(I_RESET_N) && !O_EXTERNAL_ARBITER &&
		!$past(O_EXTERNAL_ARBITER) |-> O_ARB_REQ_N == $past(I_SEC_REQ_N))
		else $error("internal request routing wrong");
	a_ext_grant_in: assert property ($past(I_RESET_N) && O_EXTERNAL_ARBITER &&
		$past(O_EXTERNAL_ARBITER) |-> O_BRIDGE_BUS_GRANT == !$past(I_SEC_REQ_N[0])
		&& O_ARB_REQ_N == '1) else $error("external grant input wrong");
	a_ext_req_out: assert property ($past(I_RESET_N) && O_EXTERNAL_ARBITER &&
		$past(O_EXTERNAL_ARBITER) |-> O_SEC_GNT_N[0] == !$past(I_BRIDGE_BUS_REQ))
		else $error("bridge request on grant zero wrong");
	a_strap_capture: assert property ($rose(O_STRAPS_VALID) |->
		{O_EXTERNAL_ARBITER, O_CLOCK_STOP_SUPPORT, O_LINK_COMPAT_MODE, O_SERIAL_BUS_MODE}
		== {$past(I_ARBITER_SOURCE_STRAP), $past(I_CLOCK_STOP_SUPPORT_STRAP),
		$past(I_GP_PIN[2]), $past(I_GP_PIN[5])}) else $error("strap capture wrong");
	a_straps_held: assert property (O_STRAPS_VALID && $past(O_STRAPS_VALID) |->
		$stable({O_EXTERNAL_ARBITER, O_CLOCK_STOP_SUPPORT, O_LINK_COMPAT_MODE,
		O_SERIAL_BUS_MODE})) else $error("captured straps changed");
	a_pin0_released: assert property (O_CLOCK_STOP_ACTIVE &&
		$past(O_CLOCK_STOP_ACTIVE) |-> O_GP_PIN_OE_N[0]) else $error("pin zero driven");
	a_ovrd_decode: assert property ($past(O_STRAPS_VALID) && O_STRAPS_VALID |->
		O_POWER_OVERRIDE_ACTIVE == ($past(I_POWER_OVERRIDE_FIELD) inside {3'h1, 3'h3}))
		else $error("override decode wrong");
	a_gp_direction: assert property ($past(O_STRAPS_VALID, 3) && O_STRAPS_VALID |->
		{O_GP_PIN_OE_N[7:6], O_GP_PIN_OE_N[3:2]} ==
		~{$past(I_PIN_DIRECTION[7:6]), $past(I_PIN_DIRECTION[3:2])})
		else $error("gp direction wrong");
endmodule : strap_mux_monitor
bind bridge_strap_pin_mux strap_mux_monitor #(.REQ_COUNT(REQ_COUNT)) strap_mux_monitor_i (
	.I_SYS_CLK(I_SYS_CLK), .I_RESET_N(I_RESET_N), .I_ARBITER_SOURCE_STRAP(I_ARBITER_SOURCE_STRAP),
	.I_CLOCK_STOP_SUPPORT_STRAP(I_CLOCK_STOP_SUPPORT_STRAP), .I_PIN_DIRECTION(I_PIN_DIRECTION),
	.I_POWER_OVERRIDE_FIELD(I_POWER_OVERRIDE_FIELD), .I_GP_PIN(I_GP_PIN),
	.I_SEC_REQ_N(I_SEC_REQ_N), .I_BRIDGE_BUS_REQ(I_BRIDGE_BUS_REQ),
	.O_GP_PIN_OE_N(O_GP_PIN_OE_N), .O_ARB_REQ_N(O_ARB_REQ_N), .O_SEC_GNT_N(O_SEC_GNT_N),
	.O_BRIDGE_BUS_GRANT(O_BRIDGE_BUS_GRANT), .O_EXTERNAL_ARBITER(O_EXTERNAL_ARBITER),
	.O_CLOCK_STOP_SUPPORT(O_CLOCK_STOP_SUPPORT), .O_CLOCK_STOP_ACTIVE(O_CLOCK_STOP_ACTIVE),
	.O_POWER_OVERRIDE_ACTIVE(O_POWER_OVERRIDE_ACTIVE), .O_SERIAL_BUS_MODE(O_SERIAL_BUS_MODE),
	.O_LINK_COMPAT_MODE(O_LINK_COMPAT_MODE), .O_STRAPS_VALID(O_STRAPS_VALID));

/* sim/bridge_strap_pin_mux_bench.sv */
// self-checking bench for the strap decoder and pin mux
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks++; if ((a) !== (e)) begin n_mismatch++; \
	$display("wrong value %s exp %h got %h", n, e, a); end end
module bridge_strap_pin_mux_bench;
	logic clk = 0, rst_n = 0, link_n = 0, arb_s = 0, cs_s = 0, cs_mode = 0, ovl = 0;
	logic scl_lo = 0, sda_lo = 0, breq = 0, sec_rst = 0, pme_n = 1, agr = 0;
	logic [7:0] dir = 0, gdo = 0, pull = 8'h04;
	logic [2:0] fld = 0;
	logic [5:0] req_n = '1, agnt_n = '1;
	wire [7:0] pin, gp, oe_n, gin;
	wire [5:0] areq, sgnt;
	wire bgr, ext, css, csa, csr, poa, sbm, sci, sdi, cmp, srn, pa, pev, sv;
	int checks = 0, n_mismatch = 0, np;
	bridge_strap_pin_mux #(.REQ_COUNT(6)) bridge_strap_pin_mux_i (.I_SYS_CLK(clk),
		.I_RESET_N(rst_n), .I_LINK_RESET_N(link_n), .I_ARBITER_SOURCE_STRAP(arb_s),
		.I_CLOCK_STOP_SUPPORT_STRAP(cs_s), .I_CLOCK_STOP_MODE(cs_mode), .I_PIN_DIRECTION(dir),
		.I_GP_OUT_DATA(gdo), .I_POWER_OVERRIDE_FIELD(fld), .I_POWER_OVERRIDE_LEVEL(ovl),
		.I_SERIAL_CLK_DRIVE_LOW(scl_lo), .I_SERIAL_DATA_DRIVE_LOW(sda_lo), .I_GP_PIN(pin),
		.I_SEC_REQ_N(req_n), .I_ARB_GNT_N(agnt_n), .I_ARB_BRIDGE_GRANT(agr),
		.I_BRIDGE_BUS_REQ(breq), .I_SEC_RESET_ASSERT(sec_rst), .I_PME_N(pme_n), .O_GP_PIN(gp),
		.O_GP_PIN_OE_N(oe_n), .O_GP_IN_DATA(gin), .O_ARB_REQ_N(areq), .O_SEC_GNT_N(sgnt),
		.O_BRIDGE_BUS_GRANT(bgr), .O_EXTERNAL_ARBITER(ext), .O_CLOCK_STOP_SUPPORT(css),
		.O_CLOCK_STOP_ACTIVE(csa), .O_CLOCK_STOP_REQUEST_N(csr), .O_POWER_OVERRIDE_ACTIVE(poa),
		.O_SERIAL_BUS_MODE(sbm), .O_SERIAL_CLK_IN(sci), .O_SERIAL_DATA_IN(sdi),
		.O_LINK_COMPAT_MODE(cmp), .O_SEC_BUS_RESET_N(srn), .O_PME_ACTIVE(pa),
		.O_PME_EVENT(pev), .O_STRAPS_VALID(sv));
	board_model board_model_i (.i_drive(gp), .i_oe_n(oe_n), .i_pull_up(pull), .o_pin(pin));
	always #25 clk = ~clk;
	task tick(int n = 1);
		repeat (n) @(posedge clk);
		#1;
	endtask : tick
	task end_sim;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : end_sim
	task t_cap(logic a, logic c, logic [7:0] pl);
		link_n = 0;
		arb_s = a;
		cs_s = c;
		pull = pl;
		tick(3);
		link_n = 1;
		tick(2);
		`CHK("straps", {1'h1, a, c, pl[2], pl[5]}, {sv, ext, css, cmp, sbm})
		arb_s = ~a;
		cs_s = ~c;
		pull = ~pl;
		tick(2);
		`CHK("held", {a, c, pl[2], pl[5]}, {ext, css, cmp, sbm})
		pull = pl;
		$display("test capture done");
	endtask : t_cap
	task t_arb_int;
		req_n = 6'h2a;
		agnt_n = 6'h15;
		agr = 1;
		tick;
		`CHK("internal", {6'h2a, 6'h15, 1'h1}, {areq, sgnt, bgr})
		$display("test internal arbiter done");
	endtask : t_arb_int
	task t_arb_ext;
		req_n = 6'h3e;
		breq = 1;
		tick;
		`CHK("ext on", {6'h3f, 1'h1, 1'h0}, {areq, bgr, sgnt[0]})
		req_n = 6'h3f;
		breq = 0;
		tick;
		`CHK("ext off", {1'h0, 1'h1}, {bgr, sgnt[0]})
		$display("test external arbiter done");
	endtask : t_arb_ext
	task t_pins;
		dir = 8'hcd;
		gdo = 8'h49;
		tick(3);
		`CHK("gp", {8'h32, 8'h49, 8'h49}, {oe_n, gp, gin})
		cs_mode = 1;
		tick(4);
		`CHK("clock stop", {1'h1, 1'h1, 1'h0}, {csa, oe_n[0], csr})
		pull = 8'h05;
		tick(2);
		`CHK("clock stop pin", 1'h1, csr)
		pull = 8'h04;
		cs_mode = 0;
		$display("test pins done");
	endtask : t_pins
	task t_ovr;
		logic e;
		ovl = 1;
		for (int f = 0; f < 8; f++) begin
			fld = f[2:0];
			tick(3);
			e = (f == 1 || f == 3);
			`CHK("override", {e, ~e, e}, {poa, oe_n[1], gp[1]})
		end
		fld = 0;
		$display("test override done");
	endtask : t_ovr
	task t_serial;
		dir = 8'h30;
		gdo = 8'h30;
		tick(3);
		`CHK("serial idle", 2'h3, oe_n[5:4])
		scl_lo = 1;
		sda_lo = 1;
		tick(3);
		`CHK("serial low", {2'h0, 2'h0}, {oe_n[5:4], gp[5:4]})
		`CHK("serial in", 2'h0, {sci, sdi})
		t_cap(1'h1, 1'h0, 8'h04);
		tick(3);
		`CHK("gp 4 5", {2'h0, 2'h3}, {oe_n[5:4], gp[5:4]})
		scl_lo = 0;
		sda_lo = 0;
		$display("test serial done");
	endtask : t_serial
	task t_misc;
		sec_rst = 1;
		tick;
		`CHK("sec reset on", 1'h0, srn)
		sec_rst = 0;
		tick;
		`CHK("sec reset off", 1'h1, srn)
		pme_n = 0;
		np = 0;
		repeat (4) begin
			tick;
			np += pev;
		end
		`CHK("pme", {1'h1, 32'h1}, {pa, np})
		pme_n = 1;
		$display("test misc done");
	endtask : t_misc
	task t_greset;
		rst_n = 0;
		#2;
		`CHK("async reset", {8'hff, 1'h0, 1'h0, 1'h0}, {oe_n, srn, sv, pev})
		tick(2);
		rst_n = 1;
		tick(3);
		`CHK("recapture", 1'h1, sv)
		$display("test global reset done");
	endtask : t_greset
	initial begin
		#200000;
		n_mismatch++;
		end_sim;
	end
	initial begin
		tick(12);
		`CHK("reset", {8'hff, 1'h0, 1'h0}, {oe_n, srn, sv})
		rst_n = 1;
		link_n = 1;
		tick(2);
		t_cap(1'h0, 1'h1, 8'h04);
		t_arb_int;
		t_pins;
		t_ovr;
		t_misc;
		t_cap(1'h1, 1'h0, 8'h20);
		t_arb_ext;
		t_serial;
		t_greset;
		end_sim;
	end
endmodule : bridge_strap_pin_mux_bench
